/* File: verilog/cts_cfg.svh */
// Constants for the console trace-stop control block.
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH
// Register byte offsets on the Wishbone bus.
`define CTS_OFF_CTRL 5'h00
`define CTS_OFF_TADDR 5'h04
`define CTS_OFF_INST 5'h08
`define CTS_OFF_CALT 5'h0c
`define CTS_OFF_STAT 5'h10
// Control register fields.
`define CTS_CTRL_MODE_LSB 0
`define CTS_CTRL_TTYPE_LSB 2
`define CTS_CTRL_OPSW_LSB 5
`define CTS_CTRL_RST 32'h0000_0000
// Trace address register fields.
`define CTS_TADDR_VAL_LSB 0
`define CTS_TADDR_CARE_LSB 16
`define CTS_TADDR_RST 32'h0000_0000
// Instruction word layout.
`define CTS_IR_OP_LSB 22
`define CTS_IR_OPC_LSB 25
`define CTS_IR_M_LSB 6
// Opcodes and codes used when forcing the instruction register.
`define CTS_OPC_CJUMP 5'h1a
`define CTS_OPC_RJUMP 5'h1b
`define CTS_C_SKIP 6'h3f
`define CTS_C_TEST_BIT 5
`endif

/* File: verilog/cts_pkg.sv */
// Types shared by the console trace-stop control block.
package cts_pkg;
  // Operating mode selected on the panel.
  typedef enum logic [1:0] {CTS_RUN, CTS_ONE_CYCLE, CTS_ONE_INST, CTS_TRACE} cts_mode_t;
  // Trace type selection; one code at a time.
  typedef enum logic [2:0] {CTS_T_OPC, CTS_T_CC, CTS_T_PROC, CTS_T_WRITE, CTS_T_IO} cts_ttype_t;
  // Stop control state.
  typedef enum logic {CTS_ST_RUN, CTS_ST_HALT} cts_state_t;
  // One memory reference seen on the shared memory port.
  typedef struct packed {
    logic valid;
    logic io;
    logic write;
    logic [14:0] addr;
  } cts_mref_t;
  // Trace setup as held in the registers.
  typedef struct packed {
    cts_ttype_t ttype;
    logic [4:0] opc;
    logic [14:0] val;
    logic [14:0] care;
  } cts_tset_t;
endpackage

/* File: verilog/cts_sync.sv */
// Two-flop synchroniser for panel inputs.
`timescale 1ns/10ps
module cts_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous in, synchronous out.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r; // First stage, read only by the second.
  // Both stages clear on reset so no button looks pressed at release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      q_o <= '0;
    end else begin
      s1_r <= d_i;
      q_o <= s1_r;
    end
  end
endmodule // cts_sync

/* File: verilog/cts_trace_cmp.sv */
// Trace comparator: opcode and address matching with a care mask.
`timescale 1ns/10ps
module cts_trace_cmp (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Setup and enable.
  input wire logic en_i,
  input wire cts_pkg::cts_tset_t set_i,
  // Core activity.
  input wire logic stat_i,
  input wire logic [4:0] opc_i,
  input wire logic [14:0] cc_i,
  input wire cts_pkg::cts_mref_t ref_i,
  // Registered stop request.
  output logic hit_o
);
  import cts_pkg::*;
  // A cleared care bit is a neutral switch and matches either value.
  function automatic logic addr_hit(input logic [14:0] a, input logic [14:0] v,
                                    input logic [14:0] c);
    addr_hit = ((a ^ v) & c) == 15'h0000;
  endfunction
  wire ref_hit = ref_i.valid && addr_hit(ref_i.addr, set_i.val, set_i.care);
  logic hit_nxt; // Combined match for this cycle.
  // Only the selected type can fire; the code field makes them exclusive.
  always_comb begin
    hit_nxt = 1'b0;
    case (set_i.ttype)
      CTS_T_OPC: hit_nxt = stat_i && (opc_i == set_i.opc);
      CTS_T_CC: hit_nxt = stat_i && addr_hit(cc_i, set_i.val, set_i.care);
      CTS_T_PROC: hit_nxt = ref_hit && !ref_i.io;
      CTS_T_WRITE: hit_nxt = ref_hit && ref_i.write;
      CTS_T_IO: hit_nxt = ref_hit && ref_i.io;
      default: hit_nxt = 1'b0;
    endcase
  end
  // Registering the match lets a traced write finish before the stop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= en_i && hit_nxt;
    end
  end
endmodule // cts_trace_cmp

/* File: verilog/cts_console.sv */
// Console trace-stop and panel control with a Wishbone register slave.
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "cts_cfg.svh"
module cts_console (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Panel buttons and switches (asynchronous).
  input wire logic btn_start_i,
  input wire logic btn_stop_i,
  input wire logic btn_next_m_i,
  input wire logic btn_next_cc_i,
  input wire logic btn_abn_i,
  input wire logic maint_offnorm_i,
  // Core status on the same clock.
  input wire logic stat_i,
  input wire logic cycle_i,
  input wire logic [29:0] ir_i,
  input wire logic [14:0] cc_i,
  input wire cts_pkg::cts_mref_t ref_i,
  input wire logic par_err_i,
  input wire logic par_err_io_i,
  input wire logic even_par_rd_i,
  input wire logic c1_normal_i,
  input wire logic c1_inh_rel_i,
  input wire logic c3_inh_set_i,
  input wire logic c3_inh_rel_i,
  // Core control.
  output logic halt_o,
  output logic ir_ld_o,
  output logic [29:0] ir_ld_val_o,
  output logic end_stat_o,
  output logic ind_wr_o,
  output logic [5:0] ind_val_o,
  // Panel lamps.
  output logic lamp_trace_o,
  output logic lamp_parity_o,
  output logic lamp_abn_o,
  output logic lamp_c3_o,
  output logic lamp_next_m_o,
  output logic lamp_next_cc_o
);
  import cts_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Panel input synchronisation and edge detection.
  //////////////////////////////////////////////////////////////////////////////

  logic [5:0] pan_raw; // Raw panel pins.
  logic [5:0] pan_s; // Synchronised panel pins.
  logic [4:0] btn_q_r; // Previous synchronised button levels.
  assign pan_raw = {maint_offnorm_i, btn_abn_i, btn_next_cc_i, btn_next_m_i,
                    btn_stop_i, btn_start_i};

  // Every panel pin passes two flops before anything reads it.
  cts_sync #(.W(6)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pan_raw),
    .q_o(pan_s)
  );

  // Buttons act once per press, on the rising edge of the clean level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_q_r <= 5'h00;
    end else begin
      btn_q_r <= pan_s[4:0];
    end
  end
  wire [4:0] btn_edge = pan_s[4:0] & ~btn_q_r; // One-cycle press pulses.
  wire start_p = btn_edge[0]; // Start pressed.
  wire stop_p = btn_edge[1]; // Program stop pressed.
  wire nm_p = btn_edge[2]; // Next-instruction M pressed.
  wire ncc_p = btn_edge[3]; // Next-instruction CC pressed.
  wire abn_p = btn_edge[4]; // Abnormal button pressed.
  wire offnorm = pan_s[5]; // Maintenance switch off normal.

  //////////////////////////////////////////////////////////////////////////////
  // Register file.
  //////////////////////////////////////////////////////////////////////////////

  logic [31:0] ctrl_r; // Mode, trace type and opcode switches.
  logic [31:0] taddr_r; // Trace address value and care mask.
  logic [29:0] alt_inst_r; // Operator-entered instruction.
  logic alt_pend_r; // Entered instruction waits for start.
  logic [5:0] calt_r; // Pending constant-field alteration.
  logic calt_pend_r; // Alteration waits to be applied.
  logic ack_r; // Bus acknowledge.
  logic [31:0] dat_r; // Read data.

  // Byte-lane merge used by the control and trace address registers.
  function automatic logic [31:0] lane_wr(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_wr[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  wire bus_req = cyc_i && stb_i && !ack_r; // New access this cycle.
  wire bus_wr = bus_req && we_i; // Write strobe.
  wire wr_ctrl = bus_wr && (adr_i == `CTS_OFF_CTRL); // Control write.
  wire wr_taddr = bus_wr && (adr_i == `CTS_OFF_TADDR); // Trace address write.
  wire wr_inst = bus_wr && (adr_i == `CTS_OFF_INST); // Instruction entry.
  wire wr_calt = bus_wr && (adr_i == `CTS_OFF_CALT); // Constant alteration.

  // Decoded setup fields.
  cts_mode_t mode;
  cts_tset_t tset;
  assign mode = cts_mode_t'(ctrl_r[`CTS_CTRL_MODE_LSB +: 2]);
  assign tset.ttype = cts_ttype_t'(ctrl_r[`CTS_CTRL_TTYPE_LSB +: 3]);
  assign tset.opc = ctrl_r[`CTS_CTRL_OPSW_LSB + 3 +: 5];
  assign tset.val = taddr_r[`CTS_TADDR_VAL_LSB +: 15];
  assign tset.care = taddr_r[`CTS_TADDR_CARE_LSB +: 15];

  // Setup registers take byte lanes; reserved bits stay zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CTS_CTRL_RST;
      taddr_r <= `CTS_TADDR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= lane_wr(ctrl_r, dat_i, sel_i) & 32'h0000_1fff;
      end
      if (wr_taddr) begin
        taddr_r <= lane_wr(taddr_r, dat_i, sel_i) & 32'h7fff_7fff;
      end
    end
  end

  // Status word read back by software.
  cts_state_t st_r;
  logic trace_r, par_r, abn_r, c3_r, nm_lamp_r, ncc_lamp_r;
  wire [31:0] stat_word = {23'h000000, alt_pend_r, ncc_lamp_r, nm_lamp_r, c3_r,
                           lamp_abn_o, abn_r, par_r, trace_r, st_r == CTS_ST_HALT};

  // Read mux; unmapped offsets read zero and are still acknowledged.
  logic [31:0] rd_mux;
  always_comb begin
    case (adr_i)
      `CTS_OFF_CTRL: rd_mux = ctrl_r;
      `CTS_OFF_TADDR: rd_mux = taddr_r;
      `CTS_OFF_INST: rd_mux = {2'b00, alt_inst_r};
      `CTS_OFF_CALT: rd_mux = {26'h0000000, calt_r};
      `CTS_OFF_STAT: rd_mux = stat_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state: ack follows the request by one edge and drops after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      dat_r <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  //////////////////////////////////////////////////////////////////////////////
  // Trace comparator.
  //////////////////////////////////////////////////////////////////////////////

  logic trace_hit; // Registered match.
  cts_trace_cmp u_cmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(mode == CTS_TRACE && st_r == CTS_ST_RUN),
    .set_i(tset),
    .stat_i(stat_i),
    .opc_i(ir_i[`CTS_IR_OPC_LSB +: 5]),
    .cc_i(cc_i),
    .ref_i(ref_i),
    .hit_o(trace_hit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Stop control.
  //////////////////////////////////////////////////////////////////////////////

  wire stopped = (st_r == CTS_ST_HALT); // Processor held.
  wire ir_op_jump = (ir_i[`CTS_IR_OPC_LSB +: 5] == `CTS_OPC_CJUMP) ||
                    (ir_i[`CTS_IR_OPC_LSB +: 5] == `CTS_OPC_RJUMP); // Jump in register.
  wire inst_stop = (mode == CTS_ONE_INST) && stat_i;
  wire cyc_stop = (mode == CTS_ONE_CYCLE) && cycle_i; // One-cycle step done.
  wire cond_stop = trace_hit || inst_stop || cyc_stop; // Stop condition met.
  wire start_ok = start_p && stopped && !abn_r;

  // Halting only holds instruction flow; memory traffic of the units goes on.
  cts_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      CTS_ST_RUN: begin
        if (cond_stop || stop_p || abn_r) begin
          st_nxt = CTS_ST_HALT;
        end
      end
      CTS_ST_HALT: begin
        if (start_ok) begin
          st_nxt = CTS_ST_RUN;
        end
      end
      default: st_nxt = CTS_ST_HALT;
    endcase
  end

  // Reset leaves the processor stopped until the operator starts it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= CTS_ST_HALT;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign halt_o = stopped;

  // Trace-stop lamp: a stop condition while running sets it, the stop button does not; start clears it, and a stop condition on that edge is ignored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trace_r <= 1'b0;
    end else if (!stopped && cond_stop) begin
      trace_r <= 1'b1;
    end else if (start_ok) begin
      trace_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction register forcing.
  //////////////////////////////////////////////////////////////////////////////

  // Entered instruction is held until start uses it; a constant alteration is pending for one cycle only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_inst_r <= 30'h00000000;
      alt_pend_r <= 1'b0;
      calt_r <= 6'h00;
      calt_pend_r <= 1'b0;
    end else begin
      if (wr_inst && stopped && mode == CTS_ONE_INST) begin
        alt_inst_r <= dat_i[29:0];
        alt_pend_r <= 1'b1;
      end else if (start_ok) begin
        alt_pend_r <= 1'b0;
      end
      if (wr_calt && stopped && ir_op_jump) begin
        calt_r <= dat_i[5:0];
        calt_pend_r <= 1'b1;
      end else begin
        calt_pend_r <= 1'b0;
      end
    end
  end

  // Forced words keep the operand address; only opcode or constant change.
  wire [29:0] ir_skip = {`CTS_OPC_CJUMP, ir_i[`CTS_IR_OP_LSB +: 3],
                         ir_i[`CTS_IR_M_LSB +: 16], `CTS_C_SKIP};
  wire [29:0] ir_zero_c = {ir_i[29:6], 6'h00};
  wire [29:0] ir_new_c = {ir_i[29:6], calt_r};
  wire calt_direct = calt_pend_r && !calt_r[`CTS_C_TEST_BIT]; // Not a test.

  // One forcing action per cycle; priority is start, then next CC, then next M, then constant alteration.
  logic ld_nxt, es_nxt;
  logic [29:0] ld_val_nxt;
  always_comb begin
    ld_nxt = 1'b0;
    es_nxt = 1'b0;
    ld_val_nxt = ir_ld_val_o;
    if (start_ok && alt_pend_r) begin
      ld_nxt = 1'b1;
      ld_val_nxt = alt_inst_r;
    end else if (ncc_p && stopped) begin
      ld_nxt = 1'b1;
      es_nxt = 1'b1;
      ld_val_nxt = ir_skip;
    end else if (nm_p && stopped && ir_op_jump) begin
      ld_nxt = 1'b1;
      ld_val_nxt = ir_zero_c;
    end else if (calt_pend_r) begin
      ld_nxt = 1'b1;
      ld_val_nxt = ir_new_c;
    end
  end

  // Load strobes are single cycles; the value stays until the next load.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_ld_o <= 1'b0;
      end_stat_o <= 1'b0;
      ir_ld_val_o <= 30'h00000000;
      ind_wr_o <= 1'b0;
      ind_val_o <= 6'h00;
    end else begin
      ir_ld_o <= ld_nxt;
      end_stat_o <= es_nxt;
      ir_ld_val_o <= ld_val_nxt;
      ind_wr_o <= calt_direct;
      if (calt_direct) begin
        ind_val_o <= calt_r;
      end
    end
  end

  // Next-instruction lamps light on a press with a jump held.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nm_lamp_r <= 1'b0;
      ncc_lamp_r <= 1'b0;
    end else if (start_ok) begin
      nm_lamp_r <= 1'b0;
      ncc_lamp_r <= 1'b0;
    end else if (ir_op_jump) begin
      if (nm_p) begin
        nm_lamp_r <= 1'b1;
        ncc_lamp_r <= 1'b0;
      end else if (ncc_p) begin
        ncc_lamp_r <= 1'b1;
        nm_lamp_r <= 1'b0;
      end
    end
  end
  assign lamp_next_m_o = nm_lamp_r;
  assign lamp_next_cc_o = ncc_lamp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Error and inhibit indicators.
  //////////////////////////////////////////////////////////////////////////////

  // Parity lamp ignores peripheral errors; a new error beats a clear.
  wire par_set = par_err_i && !par_err_io_i;
  wire par_clr = start_ok || (c1_normal_i && c1_inh_rel_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      par_r <= 1'b0;
    end else if (par_set) begin
      par_r <= 1'b1;
    end else if (par_clr) begin
      par_r <= 1'b0;
    end
  end

  // Double parity fault latches abnormal; only its own button clears it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abn_r <= 1'b0;
    end else if (even_par_rd_i && par_r) begin
      abn_r <= 1'b1;
    end else if (abn_p) begin
      abn_r <= 1'b0;
    end
  end

  // Class III lamp tracks the program inhibit; setting wins a tie.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c3_r <= 1'b0;
    end else if (c3_inh_set_i) begin
      c3_r <= 1'b1;
    end else if (c3_inh_rel_i) begin
      c3_r <= 1'b0;
    end
  end

  // Lamp outputs.
  assign lamp_trace_o = trace_r;
  assign lamp_parity_o = par_r;
  assign lamp_abn_o = abn_r || offnorm;
  assign lamp_c3_o = c3_r;
endmodule // cts_console

/* File: verif/cts_console_assertions.sv */
// Concurrent checks on the ports of the console trace-stop block.
`timescale 1ns/10ps
`include "cts_cfg.svh"
module cts_console_assertions (
  // Clock, reset and bus handshake.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Core and panel inputs that cause lamp changes.
  input wire logic par_err_i,
  input wire logic par_err_io_i,
  input wire logic maint_offnorm_i,
  input wire logic c3_inh_set_i,
  input wire logic c3_inh_rel_i,
  // Core control and lamp outputs.
  input wire logic halt_o,
  input wire logic ir_ld_o,
  input wire logic [29:0] ir_ld_val_o,
  input wire logic end_stat_o,
  input wire logic ind_wr_o,
  input wire logic [5:0] ind_val_o,
  input wire logic lamp_trace_o,
  input wire logic lamp_parity_o,
  input wire logic lamp_abn_o,
  input wire logic lamp_c3_o,
  input wire logic lamp_next_m_o,
  input wire logic lamp_next_cc_o
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // A taken request is answered in the next cycle, and the answer is one cycle long.
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  // Forcing the skip jump always carries the jump opcode and the skip code.
  chk_skip_force: assert property (end_stat_o |-> ir_ld_o &&
    ir_ld_val_o[29:25] == `CTS_OPC_CJUMP && ir_ld_val_o[5:0] == `CTS_C_SKIP)
    else $error("forced skip instruction malformed");
  // Indicators are only written directly for a code that is not a test.
  chk_ind_direct: assert property (ind_wr_o |-> ir_ld_o &&
    !ind_val_o[`CTS_C_TEST_BIT] && ir_ld_val_o[5:0] == ind_val_o)
    else $error("indicator write on a test code");
  // The trace lamp only comes on together with a halt.
  chk_trace_halt: assert property ($rose(lamp_trace_o) |-> halt_o)
    else $error("trace lamp without halt");
  // Processor parity errors light the lamp; peripheral ones never do.
  chk_par_set: assert property (par_err_i && !par_err_io_i |=> lamp_parity_o)
    else $error("parity lamp not lit");
  chk_par_io: assert property (!lamp_parity_o && !(par_err_i && !par_err_io_i)
    |=> !lamp_parity_o)
    else $error("parity lamp lit without processor error");
  // The abnormal lamp follows the maintenance switch after synchronising.
  chk_abn_follow: assert property (maint_offnorm_i [*3] |-> lamp_abn_o)
    else $error("abnormal lamp does not follow switch");
  // The class III lamp follows the program inhibit.
  chk_c3_set: assert property (c3_inh_set_i |=> lamp_c3_o)
    else $error("class III lamp not lit");
  chk_c3_clear: assert property (c3_inh_rel_i && !c3_inh_set_i |=> !lamp_c3_o)
    else $error("class III lamp not cleared");
  // Only one next-instruction path can be shown at a time.
  chk_next_excl: assert property (!(lamp_next_m_o && lamp_next_cc_o))
    else $error("both next-instruction lamps lit");
  // Main scenarios reached.
  cov_ind_wr: cover property (ind_wr_o);
  cov_skip: cover property (end_stat_o);
  cov_trace: cover property ($rose(lamp_trace_o));
endmodule // cts_console_assertions

bind cts_console cts_console_assertions i_cts_console_assertions (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .par_err_i, .par_err_io_i, .maint_offnorm_i,
  .c3_inh_set_i, .c3_inh_rel_i, .halt_o, .ir_ld_o, .ir_ld_val_o, .end_stat_o, .ind_wr_o,
  .ind_val_o, .lamp_trace_o, .lamp_parity_o, .lamp_abn_o, .lamp_c3_o,
  .lamp_next_m_o, .lamp_next_cc_o
);

/* File: verif/cts_panel_model.sv */
// Operator panel model: buttons held for a few cycles, and a maintenance switch.
`timescale 1ns/10ps
module cts_panel_model (
  // Clock.
  input wire logic clk_i,
  // One-cycle press requests and switch level from the bench.
  input wire logic [4:0] press_i,
  input wire logic maint_i,
  // Pins toward the block.
  output logic [4:0] btn_o,
  output logic maint_o
);
  // Hold counters, one per button.
  logic [2:0] cnt_r [5] = '{default: 3'h0};
  // Four cycles of hold outlast the two edges the sync chain needs.
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 5; k++) begin
      cnt_r[k] <= press_i[k] ? 3'h4 : (cnt_r[k] != 3'h0 ? cnt_r[k] - 3'h1 : 3'h0);
    end
  end
  // A released button reads as not pressed.
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      btn_o[k] = cnt_r[k] != 3'h0;
    end
  end
  assign maint_o = maint_i;
endmodule // cts_panel_model

/* File: verif/tb.sv */
// Self-checking bench for the console trace-stop block.
`timescale 1ns/10ps
`include "cts_cfg.svh"
module tb;
  import cts_pkg::*;
  // Bus, panel and core stimulus.
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, ir_ld_o, mpin;
  logic [4:0] adr_i = 0, press = 0, btn, pls = 0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 0, dat_o;
  logic stat_i = 0, cycle_i = 0, par_err_io_i = 0, c1_normal_i = 0, maint = 0;
  logic [29:0] ir_i = 0, ir_ld_val_o;
  logic [14:0] cc_i = 0;
  cts_mref_t ref_i = '0;
  logic [31:0] q_rd [$];
  logic [29:0] q_ld [$];
  int mismatches = 0, checks = 0;
  always #5 clk_i = ~clk_i;
  cts_panel_model i_cts_panel_model (.clk_i, .press_i(press), .maint_i(maint),
    .btn_o(btn), .maint_o(mpin));
  cts_console i_cts_console (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .btn_start_i(btn[0]), .btn_stop_i(btn[1]), .btn_next_m_i(btn[2]),
    .btn_next_cc_i(btn[3]), .btn_abn_i(btn[4]), .maint_offnorm_i(mpin),
    .stat_i, .cycle_i, .ir_i, .cc_i, .ref_i, .par_err_i(pls[0]), .par_err_io_i,
    .even_par_rd_i(pls[1]), .c1_normal_i, .c1_inh_rel_i(pls[2]),
    .c3_inh_set_i(pls[3]), .c3_inh_rel_i(pls[4]), .halt_o(), .ir_ld_o, .ir_ld_val_o,
    .end_stat_o(), .ind_wr_o(), .ind_val_o(), .lamp_trace_o(), .lamp_parity_o(),
    .lamp_abn_o(), .lamp_c3_o(), .lamp_next_m_o(), .lamp_next_cc_o());
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Classic single cycle; the request stands until ack is sampled.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (!ack_o);
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic press_btn(input int k);
    press[k] <= 1;
    @(posedge clk_i);
    press <= 0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulse(input int k);
    pls[k] <= 1;
    @(posedge clk_i);
    pls <= 0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic st(input logic [29:0] ir, input logic [14:0] cc);
    ir_i <= ir;
    cc_i <= cc;
    stat_i <= 1;
    @(posedge clk_i);
    stat_i <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic rf(input logic io, input logic w, input logic [14:0] x);
    ref_i <= {1'b1, io, w, x};
    @(posedge clk_i);
    ref_i <= '0;
    repeat (4) @(posedge clk_i);
  endtask
  // A miss differs in the opcode, in a cared bit or in the reference kind; a hit only in neutral bits.
  task automatic hit(input int t, input logic [14:0] a, input logic pos);
    logic [14:0] b;
    b = a ^ ((pos || t > 1) ? 15'h0005 : 15'h0010);
    case (t)
      0: st({pos ? 5'h0b : 5'h0c, 25'h0}, 15'h0);
      1: st(30'h0, b);
      2: rf(!pos, 1'b0, b);
      3: rf(pos, pos, b);
      default: rf(pos, 1'b0, b);
    endcase
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Results are compared against the oldest expectation when they appear.
  always @(posedge clk_i) begin
    if (ack_o && !we_i) chk("read data", dat_o, q_rd.size() ? q_rd.pop_front() : 'x);
    if (ir_ld_o) begin
      chk("ir load", 32'(ir_ld_val_o), q_ld.size() ? 32'(q_ld.pop_front()) : 'x);
    end
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    final_report();
  end
  initial begin : main
    logic [14:0] a;
    logic [29:0] v;
    void'($urandom(43));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h0);
    wb(1, 5'h10, '1);
    rd(5'h10, 32'h1);
    wb(1, 5'h14, '1);
    rd(5'h14, 32'h0);
    // Every trace type, each with a miss and then a hit.
    for (int t = 0; t < 5; t++) begin
      a = 15'($urandom);
      wb(1, 5'h04, {1'b0, 15'h7ff0, 1'b0, a});
      wb(1, 5'h00, {19'h0, 5'h0b, 3'h0, 3'(t), 2'h3});
      press_btn(0);
      rd(5'h10, 32'h0);
      hit(t, a, 0);
      rd(5'h10, 32'h0);
      hit(t, a, 1);
      rd(5'h10, 32'h3);
    end
    wb(1, 5'h00, 32'h0000_000c);
    press_btn(0);
    rf(1'b1, 1'b1, a ^ 15'h0005);
    rd(5'h10, 32'h0);
    par_err_io_i <= 1;
    pulse(0);
    rd(5'h10, 32'h0);
    par_err_io_i <= 0;
    pulse(0);
    rd(5'h10, 32'h4);
    c1_normal_i <= 1;
    pulse(2);
    rd(5'h10, 32'h0);
    pulse(0);
    pulse(1);
    rd(5'h10, 32'h1d);
    press_btn(0);
    rd(5'h10, 32'h1d);
    press_btn(4);
    rd(5'h10, 32'h5);
    press_btn(0);
    rd(5'h10, 32'h0);
    maint <= 1;
    repeat (4) @(posedge clk_i);
    rd(5'h10, 32'h10);
    maint <= 0;
    repeat (4) @(posedge clk_i);
    rd(5'h10, 32'h0);
    pulse(3);
    rd(5'h10, 32'h20);
    pulse(4);
    rd(5'h10, 32'h0);
    // Orderly stop, then an entered instruction in one-instruction mode.
    press_btn(1);
    st(30'h0, 15'h0);
    rd(5'h10, 32'h1);
    wb(1, 5'h00, 32'h2);
    v = {5'h01, 25'($urandom)};
    wb(1, 5'h08, {2'h0, v});
    rd(5'h10, 32'h101);
    q_ld.push_back(v);
    press_btn(0);
    st(30'h0, 15'h0);
    rd(5'h10, 32'h3);
    // One-cycle mode: a finished machine cycle stops the processor again.
    wb(1, 5'h00, 32'h1);
    press_btn(0);
    rd(5'h10, 32'h0);
    cycle_i <= 1;
    @(posedge clk_i);
    cycle_i <= 0;
    repeat (2) @(posedge clk_i);
    rd(5'h10, 32'h3);
    // Both jump opcodes: constant alteration and the two next-instruction buttons.
    for (int j = 0; j < 2; j++) begin
      v = {`CTS_OPC_CJUMP + 5'(j), 19'($urandom), 6'h05};
      ir_i <= v;
      @(posedge clk_i);
      q_ld.push_back({v[29:6], 6'h0c});
      wb(1, 5'h0c, 32'h0c);
      q_ld.push_back({v[29:6], 6'h2c});
      wb(1, 5'h0c, 32'h2c);
      q_ld.push_back({v[29:6], 6'h00});
      press_btn(2);
      q_ld.push_back({`CTS_OPC_CJUMP, v[24:6], `CTS_C_SKIP});
      press_btn(3);
      rd(5'h10, 32'h83);
    end
    repeat (4) @(posedge clk_i);
    chk("queues empty", 32'(q_rd.size() + q_ld.size()), 32'h0);
    final_report();
  end
endmodule // tb
